// file: verilog/memmap_cfg.svh
// memmap_cfg.svh: address bounds and encodings of the default memory map decoder.
// assumes 32-bit byte addresses from the core's fetch and load/store paths.
`ifndef MEMMAP_CFG_SVH
`define MEMMAP_CFG_SVH

`define MM_SRAM_BASE    32'h2000_0000
`define MM_PERIPH_BASE  32'h4000_0000
`define MM_EXTRAM_BASE  32'h6000_0000
`define MM_EXTRAM_UPPER 32'h8000_0000
`define MM_EXTDEV_BASE  32'hA000_0000
`define MM_EXTDEV_NSH   32'hC000_0000
`define MM_PRIV_BASE    32'hE000_0000
`define MM_PRIV_LAST    32'hE00F_FFFF

// access size codes: byte, halfword, word
`define MM_SIZE_BYTE    2'h0
`define MM_SIZE_HALF    2'h1
`define MM_SIZE_WORD    2'h2

`endif

// file: verilog/memmap_pkg.sv
// memmap_pkg.sv: types shared by the default memory map decoder.
// assumes nothing beyond the cfg header.
`default_nettype none
package memmap_pkg;
  typedef enum logic [1:0] {
    mem_normal,
    mem_device,
    mem_strongly_ordered
  } mem_kind_type;

  typedef enum logic [1:0] {
    cache_none,
    write_through_no_allocate,
    write_back_write_allocate
  } cache_policy_type;

  typedef enum logic [2:0] {
    reg_code,
    reg_sram,
    reg_periph,
    reg_extram,
    reg_extdev,
    reg_core_private,
    reg_system_device
  } region_type;
endpackage : memmap_pkg
`default_nettype wire

// file: verilog/memmap_decoder.sv
// memmap_decoder.sv: default memory map attribute decoder with barrier sequencing.
// assumes requests synchronous to clk; protection unit attributes arrive same cycle.
//
// How it works
// - code region: normal, executable, write-through
// - static memory region: normal, executable, write-back
// - peripheral region: device, uncached, no fetch
// - external memory: lower write-back, upper write-through
// - external device: no fetch; lower shareable only
// - core private: strongly-ordered, shareable, non-executable
// - fetch allowed only from code, sram, external memory
// - enabled protection unit attributes override defaults
// - data barrier: drain before later memory access
// - sync barrier: drain before next instruction
// - instruction barrier: flush fetch, refetch after
// - strongly-ordered accesses unbuffered, in program order
// - byte addressed, ascending, words at 0-3, 4-7
// - little endian: bits 7:0 at lowest byte
// - fetch from execute-never region raises hard fault
// - device and strongly-ordered accesses kept ordered
`include "memmap_cfg.svh"
`default_nettype none
module memmap_decoder #(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // access request
  input  wire logic                          req_valid,
  input  wire logic                          req_fetch,
  input  wire logic                          req_write,
  input  wire logic [1:0]                    req_size,
  input  wire logic [ADDR_W-1:0]             req_addr,
  input  wire logic [31:0]                   req_wdata,
  // protection unit override
  input  wire logic                          prot_enable,
  input  wire logic                          prot_hit,
  input  wire memmap_pkg::mem_kind_type      prot_kind,
  input  wire logic                          prot_execute_never,
  input  wire logic                          prot_shareable,
  input  wire memmap_pkg::cache_policy_type  prot_cache,
  // barriers and outstanding transaction state
  input  wire logic                          data_memory_barrier,
  input  wire logic                          data_sync_barrier,
  input  wire logic                          instruction_sync_barrier,
  input  wire logic                          bus_outstanding,
  input  wire logic                          write_buffer_empty,
  // decoded attributes
  output logic                               attr_valid,
  output memmap_pkg::region_type             attr_region,
  output memmap_pkg::mem_kind_type           attr_kind,
  output logic                               execute_never,
  output logic                               attr_shareable,
  output memmap_pkg::cache_policy_type       attr_cache,
  output logic                               attr_bufferable,
  output logic                               bus_error,
  output logic                               hard_fault,
  output logic [3:0]                         byte_lane_en,
  output logic [31:0]                        lane_wdata,
  // sequencing
  output logic                               hold_memory,
  output logic                               hold_execute,
  output logic                               fetch_flush
);

  // ----------------------------------------------------------------
  // region decode
  // ----------------------------------------------------------------
  function automatic memmap_pkg::region_type region_of(input logic [31:0] a);
    if (a < `MM_SRAM_BASE)        region_of = memmap_pkg::reg_code;
    else if (a < `MM_PERIPH_BASE) region_of = memmap_pkg::reg_sram;
    else if (a < `MM_EXTRAM_BASE) region_of = memmap_pkg::reg_periph;
    else if (a < `MM_EXTDEV_BASE) region_of = memmap_pkg::reg_extram;
    else if (a < `MM_PRIV_BASE)   region_of = memmap_pkg::reg_extdev;
    else if (a <= `MM_PRIV_LAST)  region_of = memmap_pkg::reg_core_private;
    else                          region_of = memmap_pkg::reg_system_device;
  endfunction : region_of

  logic [31:0]                  addr32;
  memmap_pkg::region_type       region;
  memmap_pkg::mem_kind_type     def_kind;
  memmap_pkg::cache_policy_type def_cache;
  logic                         def_no_exec;
  logic                         def_sh;

  assign addr32 = 32'(req_addr);
  assign region = region_of(addr32);

  always_comb begin
    def_kind  = memmap_pkg::mem_device;
    def_cache = memmap_pkg::cache_none;
    def_no_exec = 1'b1;
    def_sh    = 1'b0;
    case (region)
      memmap_pkg::reg_code: begin
        def_kind  = memmap_pkg::mem_normal;
        def_cache = memmap_pkg::write_through_no_allocate;
        def_no_exec = 1'b0;
      end
      memmap_pkg::reg_sram: begin
        def_kind  = memmap_pkg::mem_normal;
        def_cache = memmap_pkg::write_back_write_allocate;
        def_no_exec = 1'b0;
      end
      memmap_pkg::reg_periph: begin
        def_kind = memmap_pkg::mem_device;
      end
      memmap_pkg::reg_extram: begin
        def_kind  = memmap_pkg::mem_normal;
        def_no_exec = 1'b0;
        def_cache = (addr32 < `MM_EXTRAM_UPPER) ? memmap_pkg::write_back_write_allocate
                                             : memmap_pkg::write_through_no_allocate;
      end
      memmap_pkg::reg_extdev: begin
        def_kind = memmap_pkg::mem_device;
        def_sh   = (addr32 < `MM_EXTDEV_NSH);
      end
      memmap_pkg::reg_core_private: begin
        def_kind = memmap_pkg::mem_strongly_ordered;
        def_sh   = 1'b1;
      end
      default: begin
        def_kind = memmap_pkg::mem_device;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // protection override and registered attributes
  // ----------------------------------------------------------------
  logic                         use_prot;
  memmap_pkg::mem_kind_type     fin_kind;
  logic                         fin_no_exec;
  logic                         size_bad;

  assign use_prot = prot_enable && prot_hit;
  assign fin_kind = use_prot ? prot_kind : def_kind;
  assign fin_no_exec = use_prot ? prot_execute_never : def_no_exec;
  // private region takes words only; other data access sizes raise bus_error
  assign size_bad = (region == memmap_pkg::reg_core_private)
                    && (req_size != `MM_SIZE_WORD);

  always_ff @(posedge clk) begin
    if (rst) begin
      attr_valid      <= 1'b0;
      attr_region     <= memmap_pkg::reg_code;
      attr_kind       <= memmap_pkg::mem_normal;
      execute_never   <= 1'b0;
      attr_shareable  <= 1'b0;
      attr_cache      <= memmap_pkg::cache_none;
      attr_bufferable <= 1'b0;
    end else begin
      attr_valid      <= req_valid;
      attr_region     <= region;
      attr_kind       <= fin_kind;
      execute_never   <= fin_no_exec;
      // strongly-ordered is always shareable
      attr_shareable  <= use_prot ? (prot_shareable ||
                         prot_kind == memmap_pkg::mem_strongly_ordered) : def_sh;
      attr_cache      <= use_prot ? prot_cache : def_cache;
      // no write buffering for strongly-ordered
      attr_bufferable <= (fin_kind != memmap_pkg::mem_strongly_ordered);
    end
  end

  // ----------------------------------------------------------------
  // faults
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_error  <= 1'b0;
      hard_fault <= 1'b0;
    end else begin
      bus_error  <= req_valid && !req_fetch && size_bad;
      hard_fault <= req_valid && req_fetch && fin_no_exec;
    end
  end

  // ----------------------------------------------------------------
  // little-endian byte lanes
  // ----------------------------------------------------------------
  logic [3:0]  lanes_d;
  logic [31:0] wdata_d;

  always_comb begin
    lanes_d = 4'h0;
    wdata_d = req_wdata;
    case (req_size)
      `MM_SIZE_BYTE: begin
        lanes_d = 4'h1 << addr32[1:0];
        wdata_d = {4{req_wdata[7:0]}};
      end
      `MM_SIZE_HALF: begin
        lanes_d = addr32[1] ? 4'hc : 4'h3;
        wdata_d = {2{req_wdata[15:0]}};
      end
      default: lanes_d = 4'hf;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      byte_lane_en <= 4'h0;
      lane_wdata   <= 32'h0;
    end else begin
      byte_lane_en <= (req_valid && !req_fetch) ? lanes_d : 4'h0;
      lane_wdata   <= req_write ? wdata_d : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // barrier sequencing
  // ----------------------------------------------------------------
  // ordered (device / strongly-ordered) accesses also drain before issue;
  // costs throughput but makes ordering independent of the bus fabric
  logic drained;
  logic ordered_req;
  logic mem_bar_q;
  logic sync_bar_q;

  assign drained     = !bus_outstanding && write_buffer_empty;
  assign ordered_req = req_valid && !req_fetch && fin_kind != memmap_pkg::mem_normal;

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_bar_q  <= 1'b0;
      sync_bar_q <= 1'b0;
    end else begin
      mem_bar_q  <= (mem_bar_q || data_memory_barrier) && !drained;
      sync_bar_q <= (sync_bar_q || data_sync_barrier) && !drained;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hold_memory  <= 1'b0;
      hold_execute <= 1'b0;
      fetch_flush  <= 1'b0;
    end else begin
      hold_memory  <= ((mem_bar_q || data_memory_barrier || sync_bar_q || data_sync_barrier
                       || ordered_req) && !drained);
      hold_execute <= (sync_bar_q || data_sync_barrier) && !drained;
      fetch_flush  <= instruction_sync_barrier;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_CODE_THROUGH: assert property (@(posedge clk) disable iff (rst)
    req_valid && !use_prot && addr32 < `MM_SRAM_BASE |=>
    attr_cache == memmap_pkg::write_through_no_allocate && !execute_never)
    else $error("code region attributes wrong");
  AST_SRAM_WB: assert property (@(posedge clk) disable iff (rst)
    req_valid && !use_prot && region == memmap_pkg::reg_sram |=>
    attr_cache == memmap_pkg::write_back_write_allocate && attr_kind == memmap_pkg::mem_normal)
    else $error("sram region attributes wrong");
  AST_PERIPH_DEV: assert property (@(posedge clk) disable iff (rst)
    req_valid && !use_prot && region == memmap_pkg::reg_periph |=>
    attr_kind == memmap_pkg::mem_device && execute_never && attr_cache == memmap_pkg::cache_none)
    else $error("peripheral region attributes wrong");
  AST_EXTRAM_SPLIT: assert property (@(posedge clk) disable iff (rst)
    req_valid && !use_prot && addr32 >= `MM_EXTRAM_UPPER && addr32 < `MM_EXTDEV_BASE |=>
    attr_cache == memmap_pkg::write_through_no_allocate)
    else $error("upper external memory not write-through");
  AST_EXTDEV_SH: assert property (@(posedge clk) disable iff (rst)
    req_valid && !use_prot && region == memmap_pkg::reg_extdev |=>
    attr_shareable == ($past(addr32) < `MM_EXTDEV_NSH))
    else $error("external device shareability wrong");
  AST_PRIV_SO: assert property (@(posedge clk) disable iff (rst)
    req_valid && !use_prot && region == memmap_pkg::reg_core_private |=>
    attr_kind == memmap_pkg::mem_strongly_ordered && attr_shareable && !attr_bufferable)
    else $error("private region attributes wrong");
  AST_NOEXEC_FAULT: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_fetch && !use_prot && addr32 >= `MM_PERIPH_BASE
    && addr32 < `MM_EXTRAM_BASE |=> hard_fault)
    else $error("fetch from execute-never region without fault");
  AST_OVERRIDE: assert property (@(posedge clk) disable iff (rst)
    req_valid && use_prot |=> execute_never == $past(prot_execute_never))
    else $error("protection override ignored");
  AST_SYNC_HOLD: assert property (@(posedge clk) disable iff (rst)
    data_sync_barrier && bus_outstanding |=> hold_execute && hold_memory)
    else $error("sync barrier did not stall");
  AST_PRIV_SIZE: assert property (@(posedge clk) disable iff (rst)
    req_valid && !req_fetch && region == memmap_pkg::reg_core_private
    && req_size == `MM_SIZE_BYTE |=> bus_error)
    else $error("narrow private access not flagged");
  AST_INST_FLUSH: assert property (@(posedge clk) disable iff (rst)
    instruction_sync_barrier |=> fetch_flush)
    else $error("instruction barrier did not flush");

endmodule : memmap_decoder
`default_nettype wire

// file: bench/memmap_core_model.sv
// memmap_core_model.sv: stand-in for the core's load/store side of the decoder.
// assumes the bench drives commands by non-blocking assignment at clk rising edges.
`default_nettype none
module memmap_core_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // commands from the bench
  input  wire logic [1:0]  cmd_size,
  input  wire logic [31:0] cmd_addr,
  input  wire logic        allow_bad,
  input  wire logic        pend_load,
  input  wire logic [3:0]  pend_cnt,
  // toward the decoder
  output logic [1:0]       req_size,
  output logic             bus_outstanding,
  output logic             write_buffer_empty
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pend_q;

  // one pending transaction retires per cycle, so drain time is exact
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= 4'h0;
    end else if (pend_load) begin
      pend_q <= pend_cnt;
    end else if (pend_q != 4'h0) begin
      pend_q <= pend_q - 4'h1;
    end
  end

  assign bus_outstanding    = (pend_q != 4'h0);
  assign write_buffer_empty = (pend_q == 4'h0);
  // private region gets whole words unless a fault scenario asks otherwise
  assign req_size = (cmd_addr[31:20] == 12'he00 && !allow_bad) ? 2'h2 : cmd_size;
endmodule : memmap_core_model
`default_nettype wire

// file: bench/memmap_decoder_tb.sv
// memmap_decoder_tb.sv: self-checking bench for the default memory map decoder.
// assumes the decoder answers every request one clock later, registered.
`default_nettype none
module memmap_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_fetch = 1'b0, req_write = 1'b0;
  logic allow_bad = 1'b0, pend_load = 1'b0, prot_enable = 1'b0, prot_hit = 1'b0;
  logic prot_execute_never = 1'b0, prot_shareable = 1'b0, mem_bar = 1'b0, sync_bar = 1'b0;
  logic inst_bar = 1'b0;
  logic [1:0]  cmd_size = 2'h0, req_size;
  logic [31:0] cmd_addr = 32'h0, req_wdata = 32'h0, lane_wdata;
  logic [3:0]  pend_cnt = 4'h0, byte_lane_en;
  memmap_pkg::mem_kind_type     prot_kind = memmap_pkg::mem_normal, attr_kind;
  memmap_pkg::cache_policy_type prot_cache = memmap_pkg::cache_none, attr_cache;
  memmap_pkg::region_type       attr_region;
  logic bus_outstanding, write_buffer_empty, attr_valid, execute_never, attr_shareable;
  logic attr_bufferable, bus_error, hard_fault, hold_memory, hold_execute, fetch_flush;
  int err_total = 0, check_count = 0, cyc = 0;
  logic [31:0] corner [18] = '{32'h0, 32'h1fff_ffff, 32'h2000_0000, 32'h3fff_ffff,
    32'h4000_0000, 32'h5fff_ffff, 32'h6000_0000, 32'h7fff_ffff, 32'h8000_0000,
    32'h9fff_ffff, 32'ha000_0000, 32'hbfff_ffff, 32'hc000_0000, 32'hdfff_ffff,
    32'he000_0000, 32'he00f_ffff, 32'he010_0000, 32'hffff_ffff};

  always #2 clk = ~clk;

  memmap_core_model core_u (.clk(clk), .rst(rst), .cmd_size(cmd_size), .cmd_addr(cmd_addr),
    .allow_bad(allow_bad), .pend_load(pend_load), .pend_cnt(pend_cnt), .req_size(req_size),
    .bus_outstanding(bus_outstanding), .write_buffer_empty(write_buffer_empty));

  memmap_decoder dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req_fetch(req_fetch),
    .req_write(req_write), .req_size(req_size), .req_addr(cmd_addr), .req_wdata(req_wdata),
    .prot_enable(prot_enable), .prot_hit(prot_hit), .prot_kind(prot_kind),
    .prot_execute_never(prot_execute_never), .prot_shareable(prot_shareable),
    .prot_cache(prot_cache), .data_memory_barrier(mem_bar), .data_sync_barrier(sync_bar),
    .instruction_sync_barrier(inst_bar), .bus_outstanding(bus_outstanding),
    .write_buffer_empty(write_buffer_empty), .attr_valid(attr_valid),
    .attr_region(attr_region), .attr_kind(attr_kind), .execute_never(execute_never),
    .attr_shareable(attr_shareable), .attr_cache(attr_cache),
    .attr_bufferable(attr_bufferable), .bus_error(bus_error), .hard_fault(hard_fault),
    .byte_lane_en(byte_lane_en), .lane_wdata(lane_wdata), .hold_memory(hold_memory),
    .hold_execute(hold_execute), .fetch_flush(fetch_flush));

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic void expect_attr(input logic [31:0] a, output memmap_pkg::region_type r,
      output memmap_pkg::mem_kind_type k, output logic no_ex, output logic sh,
      output memmap_pkg::cache_policy_type c);
    k = memmap_pkg::mem_normal;
    no_ex = 1'b0;
    sh = 1'b0;
    c = memmap_pkg::write_through_no_allocate;
    if (a < 32'h2000_0000) r = memmap_pkg::reg_code;
    else if (a < 32'h4000_0000) begin
      r = memmap_pkg::reg_sram;
      c = memmap_pkg::write_back_write_allocate;
    end else if (a >= 32'h6000_0000 && a < 32'ha000_0000) begin
      r = memmap_pkg::reg_extram;
      if (a < 32'h8000_0000) c = memmap_pkg::write_back_write_allocate;
    end else begin
      no_ex = 1'b1;
      c = memmap_pkg::cache_none;
      k = memmap_pkg::mem_device;
      if (a < 32'h6000_0000) r = memmap_pkg::reg_periph;
      else if (a < 32'he000_0000) begin
        r = memmap_pkg::reg_extdev;
        sh = (a < 32'hc000_0000);
      end else if (a <= 32'he00f_ffff) begin
        r = memmap_pkg::reg_core_private;
        k = memmap_pkg::mem_strongly_ordered;
        sh = 1'b1;
      end else r = memmap_pkg::reg_system_device;
    end
  endfunction : expect_attr

  // one request, answer checked one cycle later
  task automatic access(input logic f, input logic w, input logic [1:0] sz,
      input logic [31:0] a, input logic [31:0] d, input logic ov);
    memmap_pkg::region_type r;
    memmap_pkg::mem_kind_type k;
    memmap_pkg::cache_policy_type c;
    logic no_ex, sh;
    logic [1:0] esz;
    @(posedge clk);
    req_valid <= 1'b1;
    req_fetch <= f;
    req_write <= w & ~f;
    cmd_size <= sz;
    cmd_addr <= a;
    req_wdata <= d;
    prot_enable <= ov;
    prot_hit <= ov;
    prot_kind <= memmap_pkg::mem_kind_type'($urandom_range(2));
    prot_cache <= memmap_pkg::cache_policy_type'($urandom_range(2));
    prot_execute_never <= $urandom;
    prot_shareable <= $urandom;
    @(posedge clk);
    #1;
    expect_attr(a, r, k, no_ex, sh, c);
    if (ov) begin
      k = prot_kind;
      no_ex = prot_execute_never;
      sh = prot_shareable | (prot_kind == memmap_pkg::mem_strongly_ordered);
      c = prot_cache;
    end
    esz = (a[31:20] == 12'he00 && !allow_bad) ? 2'h2 : sz;
    check(attr_valid, 1'b1);
    check(attr_region, r);
    check(attr_kind, k);
    check(execute_never, no_ex);
    check(attr_cache, c);
    check(attr_shareable, sh);
    check(attr_bufferable, k != memmap_pkg::mem_strongly_ordered);
    check(hard_fault, f & no_ex);
    check(bus_error, !f && r == memmap_pkg::reg_core_private && esz != 2'h2);
    check(byte_lane_en, f ? 4'h0 : esz == 2'h2 ? 4'hf : esz == 2'h1 ?
      (a[1] ? 4'hc : 4'h3) : 4'h1 << a[1:0]);
    check(lane_wdata, (f || !w) ? 32'h0 : esz == 2'h0 ? {4{d[7:0]}} :
      esz == 2'h1 ? {2{d[15:0]}} : d);
  endtask : access

  // kind 0..2 barrier, 3 ordered device access, all while three transfers pend
  task automatic barrier(input int kind);
    int n;
    int fl;
    n = 0;
    fl = 0;
    @(posedge clk);
    req_valid <= 1'b0;
    prot_enable <= 1'b0;
    pend_load <= 1'b1;
    pend_cnt <= 4'h3;
    @(posedge clk);
    pend_load <= 1'b0;
    mem_bar <= (kind == 0);
    sync_bar <= (kind == 1);
    inst_bar <= (kind == 2);
    req_valid <= (kind == 3);
    req_fetch <= 1'b0;
    cmd_addr <= 32'h4000_0000;
    @(posedge clk);
    {mem_bar, sync_bar, inst_bar, req_valid} <= 4'h0;
    #1;
    check(hold_memory, kind != 2);
    check(hold_execute, kind == 1);
    repeat (8) begin
      n += (hold_memory === 1'b1);
      fl += (fetch_flush === 1'b1);
      @(posedge clk);
      #1;
    end
    if (kind < 2) check(n, 3);
    else check(n, kind == 3);
    check(fl, kind == 2);
    $display("test barrier %0d done", kind);
  endtask : barrier

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    void'($urandom(32'h6f82bd1d));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check({attr_valid, hard_fault, bus_error, hold_memory, fetch_flush, byte_lane_en}, 0);
    $display("test reset done");
    foreach (corner[i]) for (int f = 0; f < 2; f++)
      access(f[0], 1'b1, 2'($urandom_range(2)), corner[i], $urandom, 1'b0);
    allow_bad <= 1'b1;
    for (int s = 0; s < 3; s++) access(1'b0, 1'b1, s[1:0], 32'he000_e012, $urandom, 1'b0);
    $display("test corners done");
    repeat (300) access($urandom, $urandom, 2'($urandom_range(2)), $urandom, $urandom,
      ($urandom_range(3) == 0));
    allow_bad <= 1'b0;
    $display("test random done");
    for (int b = 0; b < 4; b++) barrier(b);
    summarize();
  end
endmodule : memmap_decoder_tb
`default_nettype wire
